// ---- rtl/ecsr_nv_byte.sv ----
// one non-volatile configuration byte: program clears bits, erase sets all
module ecsr_nv_byte
  import ecsr_pkg::*;
#(
  parameter logic [7:0] FACTORY = 8'hFF
) (
  input  wire logic       pclk,
  input  wire logic       por_n,
  input  wire logic       program_en,
  input  wire logic       erase_en,
  input  wire logic [7:0] wdata,
  output logic      [7:0] q
);

  logic [7:0] next_q;

  // programming can only turn ones into zeros
  always_comb begin
    next_q = q;
    if (erase_en) begin
      next_q = NV_BLANK;
    end else if (program_en) begin
      next_q = q & wdata;
    end
  end

  // only power-on sets the content; the mcu reset leaves it alone
  always_ff @(posedge pclk or negedge por_n) begin
    if (!por_n) begin
      q <= FACTORY;
    end else begin
      q <= next_q;
    end
  end

endmodule : ecsr_nv_byte

// ---- rtl/ecsr_pkg.sv ----
// package: register map, field layout and carrier types of the eeprom config shadow bank
package ecsr_pkg;

  // register indices; byte address is four times the index
  localparam logic [15:0] IDX_DIV_HI_NV  = 16'hFE10;
  localparam logic [15:0] IDX_DIV_LO_NV  = 16'hFE11;
  localparam logic [15:0] IDX_DIV_HI_WK  = 16'hFE1A;
  localparam logic [15:0] IDX_DIV_LO_WK  = 16'hFE1B;
  localparam logic [15:0] IDX_PROT_NV    = 16'hFE1C;
  localparam logic [15:0] IDX_CTRL       = 16'hFE1D;
  localparam logic [15:0] IDX_PROT_WK    = 16'hFE1F;

  localparam int          ADDR_W         = 18;
  localparam logic [17:0] ADDR_DIV_HI_NV = {IDX_DIV_HI_NV, 2'h0};
  localparam logic [17:0] ADDR_DIV_LO_NV = {IDX_DIV_LO_NV, 2'h0};
  localparam logic [17:0] ADDR_DIV_HI_WK = {IDX_DIV_HI_WK, 2'h0};
  localparam logic [17:0] ADDR_DIV_LO_WK = {IDX_DIV_LO_WK, 2'h0};
  localparam logic [17:0] ADDR_PROT_NV   = {IDX_PROT_NV, 2'h0};
  localparam logic [17:0] ADDR_CTRL      = {IDX_CTRL, 2'h0};
  localparam logic [17:0] ADDR_PROT_WK   = {IDX_PROT_WK, 2'h0};

  // non-volatile contents
  localparam logic [7:0]  NV_BLANK       = 8'hFF;
  localparam logic [7:0]  PROT_FACTORY   = 8'hF0;

  // field layout
  localparam int          DIV_LOCK_BIT   = 7;
  localparam logic [7:0]  DIV_HI_MASK    = 8'h87;  // bits 6..3 read zero
  localparam int          PERM_BIT       = 4;
  localparam logic [7:0]  PROT_WK_MASK   = 8'h1F;
  localparam logic [7:0]  CTRL_MASK      = 8'h3F;
  localparam logic [7:0]  CTRL_RESET     = 8'h00;
  localparam logic [7:0]  REG_ZERO       = 8'h00;
  localparam int          BLOCK_MSB      = 8;      // 128-byte blocks: address bits 8..7
  localparam int          BLOCK_LSB      = 7;

  // operation control bits
  typedef struct packed {
    logic unused_hi;
    logic zero_bit;
    logic array_power_off;
    logic erase_size_sel_hi;
    logic erase_size_sel_lo;
    logic address_data_latch;
    logic auto_timing;
    logic program_erase_go;
  } ecsr_ctrl_t;

  // working configuration seen by the array logic
  typedef struct packed {
    logic        divider_lock_bit;
    logic [10:0] timebase_divider_value;
    logic        permanent_protect_enable;
    logic [3:0]  block_protect;
  } ecsr_cfg_t;

endpackage : ecsr_pkg

// ---- rtl/ecsr_regs.sv ----
// eeprom configuration register bank with apb access and reset-time shadow load
module ecsr_regs
  import ecsr_pkg::*;
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              por_n,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic [8:0]        array_addr,
  output logic                   array_blocked,
  output ecsr_cfg_t              cfg,
  output ecsr_ctrl_t             ctrl
);

  logic [7:0]  nv_div_hi;
  logic [7:0]  nv_div_lo;
  logic [7:0]  nv_prot;
  logic [7:0]  div_hi;
  logic [7:0]  div_lo;
  logic [7:0]  prot_wk;
  logic [7:0]  ctrl_q;
  logic        load_pending;
  logic [7:0]  next_div_hi;
  logic [7:0]  next_div_lo;
  logic [7:0]  next_prot_wk;
  logic [7:0]  next_ctrl_q;
  logic        next_load_pending;
  logic [31:0] next_prdata;
  logic        hit;
  logic        done;
  logic        wr;
  logic        rd;
  logic        div_locked;
  logic        nv_prot_locked;
  logic        nv_op;
  logic        nv_erase;
  logic [7:0]  rd_byte;
  logic [7:0]  wbyte;

  // apb decode; a transfer completes in its first access cycle once loaded
  assign wbyte   = pwdata[7:0];
  assign hit     = (paddr == ADDR_DIV_HI_NV) || (paddr == ADDR_DIV_LO_NV) || (paddr == ADDR_DIV_HI_WK) ||
                   (paddr == ADDR_DIV_LO_WK) || (paddr == ADDR_PROT_NV) || (paddr == ADDR_CTRL) ||
                   (paddr == ADDR_PROT_WK);
  assign pready  = !load_pending;
  assign done    = psel && penable && pready;
  assign pslverr = done && !hit;
  assign wr      = done && hit && pwrite;
  assign rd      = done && hit && !pwrite;

  // security locks: a zero lock bit freezes divider bytes, a zero protect bit freezes the nv protection
  assign div_locked     = !div_hi[DIV_LOCK_BIT];
  assign nv_prot_locked = !nv_prot[PERM_BIT];
  assign nv_op          = wr && ctrl.address_data_latch;         // latch bit arms nv writes
  assign nv_erase       = ctrl.erase_size_sel_hi || ctrl.erase_size_sel_lo;  // any erase size selects erase

  // non-volatile bytes, untouched by presetn
  ecsr_nv_byte #(.FACTORY(NV_BLANK)) u_nv_div_hi (
    .pclk       (pclk),
    .por_n      (por_n),
    .program_en (nv_op && !nv_erase && !div_locked && paddr == ADDR_DIV_HI_NV),
    .erase_en   (nv_op && nv_erase && !div_locked && paddr == ADDR_DIV_HI_NV),
    .wdata      (wbyte),
    .q          (nv_div_hi)
  );
  ecsr_nv_byte #(.FACTORY(NV_BLANK)) u_nv_div_lo (
    .pclk       (pclk),
    .por_n      (por_n),
    .program_en (nv_op && !nv_erase && !div_locked && paddr == ADDR_DIV_LO_NV),
    .erase_en   (nv_op && nv_erase && !div_locked && paddr == ADDR_DIV_LO_NV),
    .wdata      (wbyte),
    .q          (nv_div_lo)
  );
  ecsr_nv_byte #(.FACTORY(PROT_FACTORY)) u_nv_prot (
    .pclk       (pclk),
    .por_n      (por_n),
    .program_en (nv_op && !nv_erase && !nv_prot_locked && paddr == ADDR_PROT_NV),
    .erase_en   (nv_op && nv_erase && !nv_prot_locked && paddr == ADDR_PROT_NV),
    .wdata      (wbyte),
    .q          (nv_prot)
  );

  // read data mux
  always_comb begin
    case (paddr)
      ADDR_DIV_HI_NV: rd_byte = nv_div_hi;
      ADDR_DIV_LO_NV: rd_byte = nv_div_lo;
      ADDR_DIV_HI_WK: rd_byte = div_hi & DIV_HI_MASK;
      ADDR_DIV_LO_WK: rd_byte = div_lo;
      ADDR_PROT_NV:   rd_byte = nv_prot;
      ADDR_CTRL:      rd_byte = ctrl_q & CTRL_MASK;
      ADDR_PROT_WK:   rd_byte = prot_wk & PROT_WK_MASK;
      default:        rd_byte = REG_ZERO;
    endcase
  end

  // next state of working registers, control and read data
  always_comb begin
    next_div_hi       = div_hi;
    next_div_lo       = div_lo;
    next_prot_wk      = prot_wk;
    next_ctrl_q       = ctrl_q;
    next_load_pending = 1'b0;
    next_prdata       = prdata;
    if (load_pending) begin
      next_div_hi  = nv_div_hi & DIV_HI_MASK;
      next_div_lo  = nv_div_lo;
      next_prot_wk = nv_prot & PROT_WK_MASK;
    end else begin
      if (psel && !penable) begin
        next_prdata = {24'h000000, rd_byte};
      end
      if (wr && !div_locked && paddr == ADDR_DIV_HI_WK) begin
        next_div_hi = wbyte & DIV_HI_MASK;
      end
      if (wr && !div_locked && paddr == ADDR_DIV_LO_WK) begin
        next_div_lo = wbyte;
      end
      if (wr && paddr == ADDR_PROT_WK) begin
        next_prot_wk = wbyte & PROT_WK_MASK;
      end
      if (rd && paddr == ADDR_PROT_NV) begin
        next_prot_wk = nv_prot & PROT_WK_MASK;
      end
      if (wr && paddr == ADDR_CTRL) begin
        next_ctrl_q = wbyte & CTRL_MASK;
      end
    end
  end

  // registers; reset values are constants, the nv copy happens on the first edge after release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_hi       <= REG_ZERO;
      div_lo       <= REG_ZERO;
      prot_wk      <= REG_ZERO;
      ctrl_q       <= CTRL_RESET;
      load_pending <= 1'b1;
      prdata       <= 32'h00000000;
    end else begin
      div_hi       <= next_div_hi;
      div_lo       <= next_div_lo;
      prot_wk      <= next_prot_wk;
      ctrl_q       <= next_ctrl_q;
      load_pending <= next_load_pending;
      prdata       <= next_prdata;
    end
  end

  // outputs toward the array logic
  assign ctrl = ecsr_ctrl_t'(ctrl_q);
  assign cfg  = '{divider_lock_bit:         div_hi[DIV_LOCK_BIT],
                  timebase_divider_value:   {div_hi[2:0], div_lo},
                  permanent_protect_enable: prot_wk[PERM_BIT],
                  block_protect:            prot_wk[3:0]};
  // block index is address bits 8..7; a set protect bit blocks program and erase
  assign array_blocked = prot_wk[array_addr[BLOCK_MSB:BLOCK_LSB]];

  a_nv_prot_keep: assert property (@(posedge pclk) disable iff (!por_n)
    !(nv_op && paddr == ADDR_PROT_NV) |=> nv_prot == $past(nv_prot))
    else $error("protection nv byte changed without a write");

  a_prot_load_fields: assert property (@(posedge pclk) disable iff (!presetn)
    load_pending |=> cfg.block_protect == $past(nv_prot[3:0]) &&
                     cfg.permanent_protect_enable == $past(nv_prot[PERM_BIT]))
    else $error("protection fields not loaded from nv byte");

  a_nv_prot_lock: assert property (@(posedge pclk) disable iff (!por_n)
    nv_prot_locked |=> nv_prot == $past(nv_prot))
    else $error("locked protection nv byte changed");

  a_div_hi_zero: assert property (@(posedge pclk) disable iff (!presetn)
    !load_pending |-> div_hi[6:3] == 4'h0 && cfg.timebase_divider_value[10:8] == div_hi[2:0])
    else $error("divider high layout wrong");

  a_div_lo_load: assert property (@(posedge pclk) disable iff (!presetn)
    load_pending |=> div_lo == $past(nv_div_lo) && !load_pending)
    else $error("divider low not loaded at reset");

  a_reset_copy: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(load_pending) |-> div_hi == ($past(nv_div_hi) & DIV_HI_MASK) && pready)
    else $error("divider high not loaded at reset");

  a_ready_after_load: assert property (@(posedge pclk) disable iff (!presetn)
    load_pending |=> pready)
    else $error("bus not ready after the reset copy");

  a_read_refresh: assert property (@(posedge pclk) disable iff (!presetn)
    (rd && paddr == ADDR_PROT_NV) |=> prot_wk == ($past(nv_prot) & PROT_WK_MASK))
    else $error("nv read did not refresh block protection");

  a_block_guard: assert property (@(posedge pclk) disable iff (!presetn)
    array_blocked == ((array_addr < 9'h080) ? cfg.block_protect[0] :
                      (array_addr < 9'h100) ? cfg.block_protect[1] :
                      (array_addr < 9'h180) ? cfg.block_protect[2] : cfg.block_protect[3]))
    else $error("block guard does not follow protect bit");

  a_ctrl_reset: assert property (@(posedge pclk) disable iff (!presetn)
    load_pending |-> ctrl_q == CTRL_RESET ##1 ctrl_q == CTRL_RESET)
    else $error("control register not zero after reset");

  a_div_lock_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (div_locked && !load_pending) |=> div_lo == $past(div_lo))
    else $error("locked divider changed");

  a_div_hi_lock_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (div_locked && !load_pending) |=> div_hi == $past(div_hi))
    else $error("locked divider high changed");

endmodule : ecsr_regs

// ---- testbench/testbench.sv ----
// self-checking bench for the eeprom configuration shadow register bank
module testbench
  import ecsr_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;

  logic              pclk;
  logic              presetn;
  logic              por_n;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic [ADDR_W-1:0] paddr;
  logic [31:0]       pwdata;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  logic [8:0]        array_addr;
  logic              array_blocked;
  ecsr_cfg_t         cfg;
  ecsr_ctrl_t        ctrl;
  int                bad_count;
  int                tests_run;
  int                cycles;
  logic [31:0]       rd;
  logic              err;

  ecsr_regs dut (.pclk(pclk), .presetn(presetn), .por_n(por_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .array_addr(array_addr), .array_blocked(array_blocked), .cfg(cfg), .ctrl(ctrl));

  // clock, 100 ns period
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  // hang guard, far above the roughly 125 cycles the run needs
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      bad_count = bad_count + 1;
      finish_test();
    end
  end

  task automatic finish_test();
    $display("comparisons %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : finish_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run = tests_run + 1;
    if (got !== exp) begin
      bad_count = bad_count + 1;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  // one apb transfer: setup, access held until pready is sampled high
  task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    forever begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [31:0] exp, input string what);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd, exp, what);
  endtask : rd_chk

  // mcu reset only; nv bytes must survive it
  task automatic mcu_reset();
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
  endtask : mcu_reset

  task automatic test_reset_values();
    rd_chk(ADDR_PROT_NV, 32'h0000_00F0, "protection nv factory");
    rd_chk(ADDR_DIV_HI_WK, 32'h0000_0087, "div hi working load");
    rd_chk(ADDR_DIV_LO_WK, 32'h0000_00FF, "div lo working load");
    rd_chk(ADDR_CTRL, 32'h0000_0000, "control reset");
    chk({24'h0, ctrl}, 32'h0000_0000, "control port reset");
    rd_chk(ADDR_PROT_WK, 32'h0000_0010, "protection working load");
  endtask : test_reset_values

  task automatic test_unmapped();
    apb(1'b1, 18'h3F878, 32'h0000_00AA);
    chk({31'h0, err}, 32'h0000_0001, "write error flag");
    apb(1'b0, 18'h3F878, 32'h0000_0000);
    chk({rd[30:0], err}, 32'h0000_0001, "read error and data");
  endtask : test_unmapped

  task automatic test_blocks();
    int i;
    apb(1'b1, ADDR_PROT_WK, 32'h0000_001A);
    for (i = 0; i < 4; i++) begin
      @(posedge pclk);
      array_addr <= 9'(i * 128 + 127);
      @(negedge pclk);
      chk({31'h0, array_blocked}, {31'h0, (i == 1 || i == 3)}, "block guard");
    end
  endtask : test_blocks

  task automatic test_prot_nv();
    apb(1'b1, ADDR_CTRL, 32'h0000_00CC);
    rd_chk(ADDR_CTRL, 32'h0000_000C, "control mask");
    chk({24'h0, ctrl}, 32'h0000_000C, "control port after write");
    apb(1'b1, ADDR_PROT_NV, 32'h0000_0000);
    rd_chk(ADDR_PROT_NV, 32'h0000_00FF, "protection nv erased");
    apb(1'b1, ADDR_CTRL, 32'h0000_0004);
    apb(1'b1, ADDR_PROT_NV, 32'h0000_00F5);
    rd_chk(ADDR_PROT_NV, 32'h0000_00F5, "protection nv programmed");
    @(negedge pclk);
    chk({27'h0, cfg.permanent_protect_enable, cfg.block_protect}, 32'h0000_0015, "read applies blocks");
    apb(1'b1, ADDR_CTRL, 32'h0000_0000);
    apb(1'b1, ADDR_PROT_WK, 32'h0000_0000);
    mcu_reset();
    rd_chk(ADDR_PROT_WK, 32'h0000_0015, "reload after reset");
    rd_chk(ADDR_PROT_NV, 32'h0000_00F5, "nv kept through reset");
    // clearing permanent protect freezes the protection nv byte
    apb(1'b1, ADDR_CTRL, 32'h0000_0004);
    apb(1'b1, ADDR_PROT_NV, 32'h0000_00E5);
    apb(1'b1, ADDR_CTRL, 32'h0000_001C);
    apb(1'b1, ADDR_PROT_NV, 32'h0000_0000);
    rd_chk(ADDR_PROT_NV, 32'h0000_00E5, "protection nv locked");
    @(negedge pclk);
    chk({27'h0, cfg.permanent_protect_enable, cfg.block_protect}, 32'h0000_0005, "read applies lock");
    apb(1'b1, ADDR_CTRL, 32'h0000_0000);
  endtask : test_prot_nv

  task automatic test_divider();
    apb(1'b1, ADDR_DIV_LO_WK, 32'h0000_005A);
    apb(1'b1, ADDR_DIV_HI_WK, 32'h0000_00FF);
    rd_chk(ADDR_DIV_HI_WK, 32'h0000_0087, "div hi reserved zero");
    chk({20'h0, cfg.divider_lock_bit, cfg.timebase_divider_value}, 32'h0000_0F5A, "divider cfg");
    apb(1'b1, ADDR_CTRL, 32'h0000_0004);
    apb(1'b1, ADDR_DIV_LO_NV, 32'h0000_003C);
    apb(1'b1, ADDR_CTRL, 32'h0000_0000);
    mcu_reset();
    rd_chk(ADDR_DIV_LO_WK, 32'h0000_003C, "div lo reload");
    rd_chk(ADDR_DIV_HI_WK, 32'h0000_0087, "div hi reload");
    // a cleared lock bit freezes both divider bytes
    apb(1'b1, ADDR_DIV_HI_WK, 32'h0000_0000);
    rd_chk(ADDR_DIV_HI_WK, 32'h0000_0000, "lock bit cleared");
    apb(1'b1, ADDR_DIV_LO_WK, 32'h0000_0011);
    rd_chk(ADDR_DIV_LO_WK, 32'h0000_003C, "locked div lo kept");
  endtask : test_divider

  // main sequence
  initial begin
    bad_count  = 0;
    tests_run  = 0;
    cycles     = 0;
    presetn    = 1'b0;
    por_n      = 1'b0;
    psel       = 1'b0;
    penable    = 1'b0;
    pwrite     = 1'b0;
    paddr      = '0;
    pwdata     = 32'h0000_0000;
    array_addr = 9'h000;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    por_n   <= 1'b1;
    test_reset_values();
    test_unmapped();
    test_blocks();
    test_prot_nv();
    test_divider();
    finish_test();
  end

endmodule : testbench
